/* File: hw/tmr_pkg.sv */
// package for the 8-bit timer compare and interrupt-flag block
// assumes: one 10 MHz clock, synchronous active-high reset, avalon-mm register access
package tmr_pkg;

  // register word indices; byte address is four times the index
  localparam logic [7:0] IDX_FLAGS = 8'h38;  // flag register
  localparam logic [7:0] IDX_MASK  = 8'h39;  // interrupt mask register
  localparam logic [7:0] IDX_CMP_A = 8'h3a;  // compare value a
  localparam logic [7:0] IDX_CMP_B = 8'h3b;  // compare value b
  localparam logic [7:0] IDX_CTRL  = 8'h3c;  // mode and force strobes

  // bit positions shared by flag and mask registers
  localparam int BIT_OVF   = 0;
  localparam int BIT_CMP_A = 1;
  localparam int BIT_CMP_B = 2;
  // control register fields
  localparam int BIT_MODE_LO = 0;
  localparam int BIT_FORCE_B = 6;
  localparam int BIT_FORCE_A = 7;

  // reset values
  localparam logic [2:0] RST_IRQ3  = 3'h0;
  localparam logic [7:0] RST_BYTE  = 8'h00;
  localparam logic [2:0] RST_MODE  = 3'h0;

  // counter landmarks
  localparam logic [7:0] CNT_MAX    = 8'hff;
  localparam logic [7:0] CNT_BOTTOM = 8'h00;

  // waveform generation modes
  typedef enum logic [2:0] {
    MODE_NORMAL = 3'h0,
    MODE_PC_FF  = 3'h1,
    MODE_CTC    = 3'h2,
    MODE_FAST   = 3'h3,
    MODE_RSV4   = 3'h4,
    MODE_PC_A   = 3'h5,
    MODE_RSV6   = 3'h6,
    MODE_FAST_A = 3'h7
  } tmr_mode_type;

  // three interrupt sources, same layout as the low flag bits
  typedef struct packed {
    logic cmp_b;
    logic cmp_a;
    logic ovf;
  } tmr_irq3_type;

  // counter side inputs
  typedef struct packed {
    logic [7:0] value;  // counter_value
    logic       tick;   // one-cycle timer clock enable
    logic       wr;     // software wrote counter_value this cycle
  } tmr_cnt_type;

endpackage : tmr_pkg

/* File: hw/tmr_cmp_unit.sv */
// one compare channel: equality, write blocking and the match event
// assumes: tick and wr are one-cycle pulses synchronous to ref_clk
`timescale 1ns/10ps
`default_nettype none
module tmr_cmp_unit (
  input  wire logic            ref_clk,    // system clock
  input  wire logic            rst,        // sync reset, active high
  input  wire tmr_pkg::tmr_cnt_type cnt,   // counter side
  input  wire logic [7:0]      cmp_value,  // compare value
  output logic                 match_evt   // registered one-cycle match pulse
);

  logic blk_ff;      // match suppressed until next tick
  logic evt_ff;      // registered event
  wire  equal_w = (cnt.value == cmp_value);          // continuous compare
  wire  fire_w  = cnt.tick & equal_w & ~blk_ff;       // allowed match

  // a counter write arms the block; the next tick consumes it
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      blk_ff <= 1'b0;
      evt_ff <= 1'b0;
    end else begin
      blk_ff <= cnt.wr | (blk_ff & ~cnt.tick);
      evt_ff <= fire_w;
    end
  end

  assign match_evt = evt_ff;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_BLOCKED_TICK: assert property (blk_ff && cnt.tick |=> !match_evt)
    else $error("match fired on tick after counter write");
  AST_MATCH_FIRES: assert property (
    cnt.tick && equal_w && !blk_ff |=> match_evt)
    else $error("equal on tick gave no match event");
  COV_BLOCKED: cover property (cnt.wr ##1 cnt.tick && equal_w);

endmodule : tmr_cmp_unit
`default_nettype wire

/* File: hw/tmr_flag_cell.sv */
// one sticky interrupt flag with write-one and vector-ack clear
// assumes: all inputs synchronous to ref_clk
`timescale 1ns/10ps
`default_nettype none
module tmr_flag_cell (
  input  wire logic ref_clk,   // system clock
  input  wire logic rst,       // sync reset, active high
  input  wire logic set_evt,   // hardware event
  input  wire logic sw_clr,    // software wrote one
  input  wire logic vec_ack,   // vector executed
  input  wire logic irq_en,    // mask bit
  input  wire logic gie,       // global interrupt enable
  output logic      flag,      // flag state
  output logic      irq        // request
);

  logic flag_ff;
  // set beats any clear so an event is never dropped
  wire nxt_flag = set_evt | (flag_ff & ~(sw_clr | vec_ack));

  always_ff @(posedge ref_clk) begin
    if (rst) flag_ff <= 1'b0;
    else     flag_ff <= nxt_flag;
  end

  assign flag = flag_ff;
  assign irq  = flag_ff & irq_en & gie;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_SET_WINS: assert property (set_evt |=> flag)
    else $error("set lost against clear");
  AST_CLR_WORKS: assert property (flag && !set_evt && (sw_clr || vec_ack) |=> !flag)
    else $error("flag not cleared");
  AST_IRQ_GATED: assert property (irq |-> flag && irq_en && gie)
    else $error("irq without all three enables");

endmodule : tmr_flag_cell
`default_nettype wire

/* File: hw/tmr_cmp_irq.sv */
// top of the timer compare-match and interrupt-flag block with avalon-mm slave
// assumes: counter, prescaler and waveform generator sit outside; their
// tick, write and value arrive synchronous to ref_clk; vector acks are pulses
`timescale 1ns/10ps
`default_nettype none
// Function
// - compare value a matched with counter continuously
// - compare value b matched with counter continuously
// - mask and flag bits 7..3 read zero
// - mask bit 2 enables compare b interrupt
// - mask bit 1 enables compare a interrupt
// - mask bit 0 enables overflow interrupt
// - flag bit 2 set on compare b match
// - compare b flag cleared by vector
// - writing one clears compare b flag
// - flag bit 1 set on compare a match
// - compare a flag cleared by vector or write-one
// - flag bit 0 set on counter overflow
// - overflow flag cleared by vector or write-one
// - overflow point depends on waveform mode
// - request needs global enable, mask, flag
// - overflow at max, bottom or top by mode
// - counter write suppresses next-tick compare match
// - force strobe moves output in normal or ctc mode only, sets no flag
module tmr_cmp_irq (
  input  wire logic              ref_clk,           // 10 mhz system clock
  input  wire logic              rst,               // sync reset, active high
  // avalon-mm slave, byte address
  input  wire logic [9:0]        avs_address,
  input  wire logic              avs_read,
  input  wire logic              avs_write,
  input  wire logic [31:0]       avs_writedata,
  input  wire logic [3:0]        avs_byteenable,
  output logic [31:0]            avs_readdata,
  output logic                   avs_waitrequest,
  // counter side
  input  wire tmr_pkg::tmr_cnt_type counter_in,     // value, tick, write
  // interrupt controller side
  input  wire logic              gie,               // cpu_status_reg global enable
  input  wire tmr_pkg::tmr_irq3_type vec_ack,       // vector executed pulses
  output tmr_pkg::tmr_irq3_type  irq_req,           // interrupt requests
  // waveform generator side
  output logic                   wave_out_a,        // match or forced event a
  output logic                   wave_out_b,        // match or forced event b
  output logic [2:0]             waveform_mode      // current mode
);

  // software registers
  logic [2:0] mask_ff;            // interrupt enables
  logic [7:0] cmp_a_ff;           // compare_value_a
  logic [7:0] cmp_b_ff;           // compare_value_b
  logic [2:0] mode_ff;            // waveform_mode
  logic       force_a_ff;         // force_cmp_a_strobe, one cycle
  logic       force_b_ff;         // force strobe for channel b
  logic       ovf_evt_ff;         // registered overflow event
  logic       wave_a_ff;          // registered wave event a
  logic       wave_b_ff;          // registered wave event b
  logic       ack_ff;             // bus answer cycle
  logic [31:0] rdata_ff;          // read data hold

  tmr_pkg::tmr_irq3_type flags_w; // flag states
  tmr_pkg::tmr_irq3_type irq_w;   // request per source
  logic       match_a;            // compare a event
  logic       match_b;            // compare b event

  // bus decode: one wait state, answer in the second cycle
  // unmapped indices fall through to zero and write nothing
  wire        req_w     = avs_read | avs_write;
  wire [7:0]  idx_w     = avs_address[9:2];
  wire        wr_acc_w  = avs_write & ack_ff & avs_byteenable[0];
  wire        wr_flags  = wr_acc_w & (idx_w == tmr_pkg::IDX_FLAGS);
  wire        wr_mask   = wr_acc_w & (idx_w == tmr_pkg::IDX_MASK);
  wire        wr_cmp_a  = wr_acc_w & (idx_w == tmr_pkg::IDX_CMP_A);
  wire        wr_cmp_b  = wr_acc_w & (idx_w == tmr_pkg::IDX_CMP_B);
  wire        wr_ctrl   = wr_acc_w & (idx_w == tmr_pkg::IDX_CTRL);
  wire [7:0]  wbyte     = avs_writedata[7:0];

  // force strobes only act in the non-pwm modes
  wire        non_pwm_w = (mode_ff == tmr_pkg::MODE_NORMAL) |
                          (mode_ff == tmr_pkg::MODE_CTC);

  // readdata is loaded in the wait cycle from this mux
  // read mux; reserved and unmapped bits read zero
  wire [7:0] rd_byte_w =
    (idx_w == tmr_pkg::IDX_FLAGS) ? {5'h00, flags_w}  :
    (idx_w == tmr_pkg::IDX_MASK)  ? {5'h00, mask_ff}  :
    (idx_w == tmr_pkg::IDX_CMP_A) ? cmp_a_ff          :
    (idx_w == tmr_pkg::IDX_CMP_B) ? cmp_b_ff          :
    (idx_w == tmr_pkg::IDX_CTRL)  ? {5'h00, mode_ff}  :   // strobes read zero
                                    8'h00;

  // overflow point chosen by waveform mode; reserved modes never overflow
  // top in mode 7 follows compare value a, so a rewrite moves it at once
  // software that selects mode 4 or 6 simply never sees an overflow flag
  wire at_max_w    = (counter_in.value == tmr_pkg::CNT_MAX);
  wire at_bottom_w = (counter_in.value == tmr_pkg::CNT_BOTTOM);
  wire at_top_a_w  = (counter_in.value == cmp_a_ff);
  logic ovf_pt_w;
  always_comb begin
    unique case (tmr_pkg::tmr_mode_type'(mode_ff))
      tmr_pkg::MODE_NORMAL, tmr_pkg::MODE_CTC,
      tmr_pkg::MODE_FAST:   ovf_pt_w = at_max_w;
      tmr_pkg::MODE_PC_FF,
      tmr_pkg::MODE_PC_A:   ovf_pt_w = at_bottom_w;
      tmr_pkg::MODE_FAST_A: ovf_pt_w = at_top_a_w;
      tmr_pkg::MODE_RSV4,
      tmr_pkg::MODE_RSV6:   ovf_pt_w = 1'b0;
    endcase
  end
  wire nxt_ovf_evt = counter_in.tick & ovf_pt_w;

  // bus handshake: waitrequest drops one cycle after a request appears
  // the fixed wait state lets read data come from a flop, not the mux;
  // the cost is two cycles per access, even back to back
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end else begin
      ack_ff   <= req_w & ~ack_ff;
      if (avs_read & ~ack_ff) rdata_ff <= {24'h00_0000, rd_byte_w};
    end
  end
  assign avs_waitrequest = req_w & ~ack_ff;
  assign avs_readdata    = rdata_ff;

  // software-written registers; upper mask bits dropped on write
  // byte lane zero gates every write; the other lanes carry nothing
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      mask_ff  <= tmr_pkg::RST_IRQ3;
      cmp_a_ff <= tmr_pkg::RST_BYTE;
      cmp_b_ff <= tmr_pkg::RST_BYTE;
      mode_ff  <= tmr_pkg::RST_MODE;
    end else begin
      if (wr_mask)  mask_ff  <= wbyte[2:0];
      if (wr_cmp_a) cmp_a_ff <= wbyte;
      if (wr_cmp_b) cmp_b_ff <= wbyte;
      if (wr_ctrl)  mode_ff  <= wbyte[tmr_pkg::BIT_MODE_LO +: 3];
    end
  end

  // strobes and wave events; a forced compare reaches only the wave path
  // the strobe is gated by the mode already held, not the one being written
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      force_a_ff <= 1'b0;
      force_b_ff <= 1'b0;
      ovf_evt_ff <= 1'b0;
      wave_a_ff  <= 1'b0;
      wave_b_ff  <= 1'b0;
    end else begin
      force_a_ff <= wr_ctrl & wbyte[tmr_pkg::BIT_FORCE_A] & non_pwm_w;
      force_b_ff <= wr_ctrl & wbyte[tmr_pkg::BIT_FORCE_B] & non_pwm_w;
      ovf_evt_ff <= nxt_ovf_evt;
      wave_a_ff  <= match_a | force_a_ff;
      wave_b_ff  <= match_b | force_b_ff;
    end
  end

  // wave outputs are one-cycle events; the generator decides the pin level
  assign wave_out_a    = wave_a_ff;
  assign wave_out_b    = wave_b_ff;
  assign waveform_mode = mode_ff;

  // compare channels
  // both channels see the same counter write, so both skip the next tick
  tmr_cmp_unit u_cmp_a (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .cnt       (counter_in),
    .cmp_value (cmp_a_ff),
    .match_evt (match_a)
  );
  tmr_cmp_unit u_cmp_b (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .cnt       (counter_in),
    .cmp_value (cmp_b_ff),
    .match_evt (match_b)
  );

  // flag cells: ovf, a, b in package bit order
  // each clears on its vector ack or a write-one; a same-cycle set survives
  tmr_flag_cell u_flag_ovf (
    .ref_clk (ref_clk),
    .rst     (rst),
    .set_evt (ovf_evt_ff),
    .sw_clr  (wr_flags & wbyte[tmr_pkg::BIT_OVF]),
    .vec_ack (vec_ack.ovf),
    .irq_en  (mask_ff[tmr_pkg::BIT_OVF]),
    .gie     (gie),
    .flag    (flags_w.ovf),
    .irq     (irq_w.ovf)
  );
  tmr_flag_cell u_flag_a (
    .ref_clk (ref_clk),
    .rst     (rst),
    .set_evt (match_a),
    .sw_clr  (wr_flags & wbyte[tmr_pkg::BIT_CMP_A]),
    .vec_ack (vec_ack.cmp_a),
    .irq_en  (mask_ff[tmr_pkg::BIT_CMP_A]),
    .gie     (gie),
    .flag    (flags_w.cmp_a),
    .irq     (irq_w.cmp_a)
  );
  tmr_flag_cell u_flag_b (
    .ref_clk (ref_clk),
    .rst     (rst),
    .set_evt (match_b),
    .sw_clr  (wr_flags & wbyte[tmr_pkg::BIT_CMP_B]),
    .vec_ack (vec_ack.cmp_b),
    .irq_en  (mask_ff[tmr_pkg::BIT_CMP_B]),
    .gie     (gie),
    .flag    (flags_w.cmp_b),
    .irq     (irq_w.cmp_b)
  );

  // requests need global enable, mask bit and flag together
  // nothing is latched here: dropping gie removes every request at once
  assign irq_req = irq_w;

  // checks below run on the system clock and pause during reset
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  AST_RSVD_ZERO: assert property (avs_read && !avs_waitrequest |->
    avs_readdata[31:3] == 29'h0 || idx_w == tmr_pkg::IDX_CMP_A || idx_w == tmr_pkg::IDX_CMP_B)
    else $error("reserved bits read nonzero");
  AST_MASK_WRITE: assert property (wr_mask |=> mask_ff == $past(wbyte[2:0]))
    else $error("mask write not stored");
  AST_ONE_WAIT: assert property (req_w && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held longer than one cycle");
  AST_A_FLAG_CAUSE: assert property (!flags_w.cmp_a && !match_a |=> !flags_w.cmp_a)
    else $error("compare a flag rose without a match");
  AST_OVF_MAX: assert property (
    mode_ff == tmr_pkg::MODE_NORMAL && counter_in.tick && at_max_w && !wr_ctrl |=> ##1 flags_w.ovf)
    else $error("overflow flag missed at max");
  AST_B_IRQ: assert property (gie && mask_ff[2] && flags_w.cmp_b |-> irq_req.cmp_b)
    else $error("compare b request missing");

  // flag set paths and wave events
  AST_CMP_A_SET: assert property (
    match_a |=> flags_w.cmp_a)
    else $error("compare a match did not set its flag");
  AST_CMP_B_SET: assert property (
    match_b |=> flags_w.cmp_b)
    else $error("compare b match did not set its flag");
  AST_OVF_SET: assert property (
    ovf_evt_ff |=> flags_w.ovf)
    else $error("overflow event did not set its flag");
  AST_MATCH_WAVE_B: assert property (
    match_b |=> wave_out_b)
    else $error("compare b match gave no wave pulse");

  // request gating
  AST_A_IRQ: assert property (
    gie && mask_ff[tmr_pkg::BIT_CMP_A] && flags_w.cmp_a |-> irq_req.cmp_a)
    else $error("compare a request missing");
  AST_OVF_IRQ: assert property (
    gie && mask_ff[tmr_pkg::BIT_OVF] && flags_w.ovf |-> irq_req.ovf)
    else $error("overflow request missing");
  AST_IRQ_NEEDS_GIE: assert property (
    !gie |-> irq_req == 3'h0)
    else $error("request raised with global enable off");

  // overflow point by mode
  AST_BOTTOM_OVF: assert property (
    (mode_ff == tmr_pkg::MODE_PC_FF || mode_ff == tmr_pkg::MODE_PC_A) &&
    counter_in.tick && at_bottom_w |=> ovf_evt_ff)
    else $error("overflow event missed at bottom");
  AST_TOP_OVF: assert property (
    mode_ff == tmr_pkg::MODE_FAST_A && counter_in.tick && at_top_a_w |=> ovf_evt_ff)
    else $error("overflow event missed at top");
  AST_RSV_NO_OVF: assert property (
    (mode_ff == tmr_pkg::MODE_RSV4 || mode_ff == tmr_pkg::MODE_RSV6) |=> !ovf_evt_ff)
    else $error("overflow event in a reserved mode");

  // force strobes and flag clears
  AST_FORCE_WAVE: assert property (
    force_a_ff |=> wave_out_a)
    else $error("forced compare a gave no wave pulse");
  AST_FORCE_PWM: assert property (
    wr_ctrl && !non_pwm_w |=> !force_a_ff && !force_b_ff)
    else $error("force strobe taken in a pwm mode");
  AST_FORCE_B_FLAG: assert property (
    force_b_ff && !match_b && !flags_w.cmp_b |=> !flags_w.cmp_b)
    else $error("forced compare b set its flag");
  AST_WRITE_B_CLR: assert property (
    wr_flags && wbyte[tmr_pkg::BIT_CMP_B] && !match_b |=> !flags_w.cmp_b)
    else $error("write one left compare b flag set");
  AST_ZERO_KEEPS_B: assert property (
    wr_flags && !wbyte[tmr_pkg::BIT_CMP_B] && !vec_ack.cmp_b && flags_w.cmp_b |=> flags_w.cmp_b)
    else $error("write zero cleared compare b flag");
  AST_VEC_A_CLR: assert property (
    vec_ack.cmp_a && !match_a |=> !flags_w.cmp_a)
    else $error("vector left compare a flag set");
  COV_OVF_IRQ: cover property (irq_req.ovf);
  COV_FORCE_A: cover property (force_a_ff ##1 wave_out_a);
  COV_SET_CLR: cover property (match_b && wr_flags && wbyte[2]);
  COV_VEC_CLR: cover property (vec_ack.ovf ##1 !flags_w.ovf);

endmodule : tmr_cmp_irq
`default_nettype wire

/* File: dv/tmr_irq_ctrl_model.sv */
// interrupt controller stand-in: runs the vector of a pending request
// assumes: irq_req and ack_en synchronous to ref_clk, reset synchronous
`timescale 1ns/10ps
`default_nettype none
module tmr_irq_ctrl_model (
  input  wire logic                  ref_clk,  // system clock
  input  wire logic                  rst,      // sync reset, active high
  input  wire logic                  ack_en,   // vectors may be taken
  input  wire logic [3:0]            lag,      // wait before a vector, at least 1
  input  wire tmr_pkg::tmr_irq3_type irq_req,  // pending requests
  input  wire tmr_pkg::tmr_irq3_type extra,    // bench-commanded vector pulses
  output tmr_pkg::tmr_irq3_type      vec_ack   // one-cycle vector pulses
);
  logic [3:0] wait_ff;  // cycles the request has waited
  logic [2:0] pick;     // lowest pending source
  logic       live;     // a request may be served
  assign pick = irq_req & ~(irq_req - 3'h1);
  assign live = ack_en && (irq_req != 3'h0);
  // lag of at least one cycle keeps a served request from being taken twice
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      wait_ff <= 4'h0;
      vec_ack <= 3'h0;
    end else if (live && wait_ff >= lag) begin
      wait_ff <= 4'h0;
      vec_ack <= pick | extra;
    end else begin
      wait_ff <= live ? wait_ff + 4'h1 : 4'h0;
      vec_ack <= extra;
    end
  end
endmodule : tmr_irq_ctrl_model
`default_nettype wire

/* File: dv/tmr_cmp_irq_tb.sv */
// self-checking bench for the timer compare and interrupt-flag block
// assumes: design package compiled first; bus is avalon-mm, one wait cycle
`timescale 1ns/10ps
`default_nettype none
module tmr_cmp_irq_tb;
  logic                  ref_clk, rst, gie, ack_en;   // clock, reset, enables
  logic [9:0]            avs_address;                 // byte address
  logic                  avs_read, avs_write;         // bus strobes
  logic [31:0]           avs_writedata, avs_readdata; // bus data
  logic [3:0]            avs_byteenable, lag;         // lanes, vector lag
  logic                  avs_waitrequest, wave_out_a, wave_out_b, seen_a, seen_b;
  logic [2:0]            waveform_mode;               // mode echo
  tmr_pkg::tmr_cnt_type  counter_in;                  // counter side
  tmr_pkg::tmr_irq3_type vec_ack, irq_req, extra;     // vector side
  logic [31:0]           rd;                          // last read data
  logic                  e;                           // expected overflow
  logic [7:0]            v;                           // tick value
  int                    num_errors, n_checks, cyc, m, j;
  tmr_cmp_irq u_tmr_cmp_irq (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .counter_in(counter_in), .gie(gie),
    .vec_ack(vec_ack), .irq_req(irq_req), .wave_out_a(wave_out_a),
    .wave_out_b(wave_out_b), .waveform_mode(waveform_mode));
  tmr_irq_ctrl_model u_tmr_irq_ctrl_model (.ref_clk(ref_clk), .rst(rst), .ack_en(ack_en),
    .lag(lag), .irq_req(irq_req), .extra(extra), .vec_ack(vec_ack));
  initial begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end
  // hang guard: a few thousand cycles cover the whole sequence
  always @(posedge ref_clk) begin
    cyc++;
    if (wave_out_a) seen_a <= 1'b1;
    if (wave_out_b) seen_b <= 1'b1;
    if (cyc == 6000) begin
      num_errors++;
      results();
    end
  end
  task automatic results();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : results
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  // one avalon transfer; request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int waits;
    waits = 0;
    @(posedge ref_clk);
    avs_address   <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_write     <= wr;
    avs_read      <= ~wr;
    @(posedge ref_clk);
    while (avs_waitrequest !== 1'b0) begin
      waits++;
      @(posedge ref_clk);
    end
    rd = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    check("bus wait", waits, 32'h1);
    // let the write settle before the caller looks at outputs
    @(negedge ref_clk);
  endtask : bus
  // one timer clock at value tv with optional vector pulses; ends in the flag cycle
  task automatic tick(input logic [7:0] tv, input logic [2:0] ack);
    @(posedge ref_clk);
    counter_in <= {tv, 1'b1, 1'b0};
    extra      <= ack;
    @(posedge ref_clk);
    counter_in.tick <= 1'b0;
    extra           <= 3'h0;
    @(posedge ref_clk);
    @(negedge ref_clk);
  endtask : tick
  // bounded wait for the controller model to serve requests
  task automatic drain();
    for (int k = 0; k < 20 && irq_req !== 3'h0; k++) @(negedge ref_clk);
  endtask : drain
  initial begin
    rst = 1'b1; gie = 1'b0; ack_en = 1'b0; lag = 4'h1; extra = 3'h0; seen_a = 1'b0;
    seen_b = 1'b0;
    avs_address = 10'h0; avs_read = 1'b0; avs_write = 1'b0; avs_writedata = 32'h0;
    avs_byteenable = 4'h1; counter_in = '0; num_errors = 0; n_checks = 0; cyc = 0;
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    // reset values, reserved bits, unmapped index
    bus(0, tmr_pkg::IDX_MASK, 8'h00); check("mask reset", rd, 32'h0);
    bus(1, tmr_pkg::IDX_MASK, 8'hff); bus(0, tmr_pkg::IDX_MASK, 8'h00);
    check("mask reserved", rd, 32'h7);
    bus(1, tmr_pkg::IDX_FLAGS, 8'hf8); bus(0, tmr_pkg::IDX_FLAGS, 8'h00);
    check("flag reserved", rd, 32'h0);
    bus(0, 8'h00, 8'h00); check("unmapped", rd, 32'h0);
    // compare a and b events, masking and software clears
    bus(1, tmr_pkg::IDX_CMP_A, 8'h40); bus(1, tmr_pkg::IDX_CMP_B, 8'h41);
    bus(1, tmr_pkg::IDX_MASK, 8'h02);
    // a write with byte lane zero off is ignored
    @(posedge ref_clk) avs_byteenable <= 4'h0;
    bus(1, tmr_pkg::IDX_CMP_B, 8'h99);
    @(posedge ref_clk) avs_byteenable <= 4'h1;
    bus(0, tmr_pkg::IDX_CMP_B, 8'h00); check("lane off", rd, 32'h41);
    tick(8'h40, 3'h0); check("wave a", wave_out_a, 1'b1);
    check("irq gie off", irq_req, 3'h0);
    @(posedge ref_clk) gie <= 1'b1;
    @(negedge ref_clk); check("irq a", irq_req, 3'h2);
    tick(8'h41, 3'h0); check("wave b", wave_out_b, 1'b1);
    check("irq b masked", irq_req, 3'h2);
    bus(0, tmr_pkg::IDX_FLAGS, 8'h00); check("flags ab", rd, 32'h6);
    bus(1, tmr_pkg::IDX_FLAGS, 8'h00); bus(0, tmr_pkg::IDX_FLAGS, 8'h00);
    check("write zero", rd, 32'h6);
    bus(1, tmr_pkg::IDX_FLAGS, 8'h02); bus(0, tmr_pkg::IDX_FLAGS, 8'h00);
    check("clear a", rd, 32'h4);
    bus(1, tmr_pkg::IDX_MASK, 8'h04); @(negedge ref_clk);
    check("irq b", irq_req, 3'h4);
    lag <= 4'h5; ack_en <= 1'b1; drain(); // slow vector
    bus(0, tmr_pkg::IDX_FLAGS, 8'h00); check("vector b", rd, 32'h0);
    tick(8'h41, 3'h0); bus(1, tmr_pkg::IDX_FLAGS, 8'h04); bus(0, tmr_pkg::IDX_FLAGS, 8'h00);
    check("clear b", rd, 32'h0);
    // overflow point over every mode; compare a sits at 0x40
    ack_en <= 1'b0; bus(1, tmr_pkg::IDX_MASK, 8'h01);
    for (m = 0; m < 8; m++) begin
      bus(1, tmr_pkg::IDX_CTRL, m[7:0]); check("mode", waveform_mode, m[2:0]);
      for (j = 0; j < 3; j++) begin
        v = (j == 0) ? 8'hff : (j == 1) ? 8'h00 : 8'h40;
        e = (j == 0 && (m == 0 || m == 2 || m == 3)) || (j == 1 && (m == 1 || m == 5))
            || (j == 2 && m == 7);
        tick(v, 3'h0); check("ovf irq", irq_req, {2'b00, e});
        bus(0, tmr_pkg::IDX_FLAGS, 8'h00);
        check("ovf flag", rd, {30'h0, j == 2, e});
        bus(1, tmr_pkg::IDX_FLAGS, 8'h07);
      end
    end
    bus(0, tmr_pkg::IDX_FLAGS, 8'h00); check("w1c all", rd, 32'h0);
    bus(1, tmr_pkg::IDX_CTRL, 8'h00);
    tick(8'hff, 3'h0); lag <= 4'h1; ack_en <= 1'b1; drain(); // prompt vector
    bus(0, tmr_pkg::IDX_FLAGS, 8'h00); check("vector ovf", rd, 32'h0);
    // counter write blocks the next match only
    @(posedge ref_clk) counter_in <= {8'h40, 1'b0, 1'b1};
    @(posedge ref_clk) counter_in.wr <= 1'b0;
    tick(8'h40, 3'h0); check("blocked", wave_out_a, 1'b0);
    tick(8'h40, 3'h0); check("unblocked", wave_out_a, 1'b1);
    // forced compare moves the output only
    ack_en <= 1'b0; bus(1, tmr_pkg::IDX_MASK, 8'h07); bus(1, tmr_pkg::IDX_FLAGS, 8'h07);
    seen_a = 1'b0; seen_b = 1'b0; bus(1, tmr_pkg::IDX_CTRL, 8'hc0); repeat (4) @(negedge ref_clk);
    check("force wave", seen_a, 1'b1); check("force irq", irq_req, 3'h0);
    check("force wave b", seen_b, 1'b1);
    bus(0, tmr_pkg::IDX_CTRL, 8'h00); check("force reads 0", rd, 32'h0);
    // a strobe written while a pwm mode is held is dropped
    bus(1, tmr_pkg::IDX_CTRL, 8'h03); seen_a = 1'b0; bus(1, tmr_pkg::IDX_CTRL, 8'h83);
    repeat (4) @(negedge ref_clk); check("force pwm", seen_a, 1'b0);
    // set and vector clear at the same edge: the set must stay
    tick(8'h40, 3'h2); bus(0, tmr_pkg::IDX_FLAGS, 8'h00);
    check("set wins", rd, 32'h2);
    @(posedge ref_clk) extra <= 3'h2;
    @(posedge ref_clk) extra <= 3'h0;
    repeat (2) @(negedge ref_clk); check("vector a", irq_req, 3'h0);
    results();
  end
endmodule : tmr_cmp_irq_tb
`default_nettype wire
